// File: core/cpu_interrupt_flag_regs.sv
// cpu interrupt flag registers with an ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none

module cpu_interrupt_flag_regs (
  input  wire logic                    i_clk_sys,      // system clock, 50 MHz
  input  wire logic                    i_rst,          // async reset, active high
  input  wire logic                    i_hsel,         // slave select
  input  wire logic [31:0]             i_haddr,        // byte address
  input  wire logic [1:0]              i_htrans,       // transfer type
  input  wire logic                    i_hwrite,       // write when high
  input  wire logic [2:0]              i_hsize,        // transfer size
  input  wire logic [31:0]             i_hwdata,       // write data
  input  wire logic                    i_hready,       // bus ready
  input  wire cpu_irq_flags_pkg::src_t i_src_set,      // set events from peripherals
  input  wire cpu_irq_flags_pkg::vec_t i_vector_taken, // cpu vectored to the routine
  output var  logic [31:0]             o_hrdata,       // read data
  output var  logic                    o_hreadyout,    // slave ready
  output var  logic                    o_hresp,        // always okay
  output var  logic                    o_irq,          // unmasked status pending
  output var  cpu_irq_flags_pkg::src_t o_irq_req       // enabled requests to cpu
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cpu_irq_flags_pkg::state_t st_reg;
  cpu_irq_flags_pkg::state_t st_next;
  logic                      wr_one;
  logic                      wr_two;
  logic                      wr_status;
  logic                      wr_mask;
  logic                      wr_enable;
  logic                      addr_read;

  // read multiplexer over the register map
  function automatic logic [31:0] read_mux(input logic [7:0]                a,
                                           input cpu_irq_flags_pkg::state_t s);
    logic [31:0] d;
    d = 32'h0;
    case (a)
      cpu_irq_flags_pkg::ADDR_FLAGS_ONE: d = {24'h0, s.flags_one};
      cpu_irq_flags_pkg::ADDR_FLAGS_TWO: d = {24'h0, s.flags_two};
      cpu_irq_flags_pkg::ADDR_STATUS:    d = {27'h0, s.status};
      cpu_irq_flags_pkg::ADDR_MASK:      d = {27'h0, s.mask};
      cpu_irq_flags_pkg::ADDR_ENABLE:    d = {27'h0, s.enable};
      default:                           d = 32'h0;
    endcase
    return d;
  endfunction : read_mux

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next   = st_reg;
    // data-phase write decode; unmapped writes fall through unused
    wr_one    = st_reg.dp_valid && st_reg.dp_write &&
                (st_reg.dp_addr == cpu_irq_flags_pkg::ADDR_FLAGS_ONE);
    wr_two    = st_reg.dp_valid && st_reg.dp_write &&
                (st_reg.dp_addr == cpu_irq_flags_pkg::ADDR_FLAGS_TWO);
    wr_status = st_reg.dp_valid && st_reg.dp_write &&
                (st_reg.dp_addr == cpu_irq_flags_pkg::ADDR_STATUS);
    wr_mask   = st_reg.dp_valid && st_reg.dp_write &&
                (st_reg.dp_addr == cpu_irq_flags_pkg::ADDR_MASK);
    wr_enable = st_reg.dp_valid && st_reg.dp_write &&
                (st_reg.dp_addr == cpu_irq_flags_pkg::ADDR_ENABLE);
    addr_read = i_hready && i_hsel && i_htrans[1] && !i_hwrite;

    // software writes land first, all bits stored as written
    if (wr_one) begin
      st_next.flags_one = i_hwdata[7:0];
    end
    if (wr_two) begin
      st_next.flags_two = i_hwdata[7:0];
    end
    if (wr_mask) begin
      st_next.mask = i_hwdata[4:0];
    end
    if (wr_enable) begin
      st_next.enable = i_hwdata[4:0];
    end

    // vector taken clears the hardware-cleared flags
    if (i_vector_taken.serial1_rx) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL1] = 1'b0;
    end
    if (i_vector_taken.converter) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_CONVERTER] = 1'b0;
    end
    if (i_vector_taken.serial0_rx) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL0] = 1'b0;
    end
    if (i_vector_taken.radio_xfer) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_RADIO] = 1'b0;
    end

    // source events set last so they win over clears, enable ignored
    if (i_src_set.serial1_rx) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL1] = 1'b1;
    end
    if (i_src_set.converter) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_CONVERTER] = 1'b1;
    end
    if (i_src_set.serial0_rx) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL0] = 1'b1;
    end
    if (i_src_set.radio_xfer) begin
      st_next.flags_one[cpu_irq_flags_pkg::BIT_RADIO] = 1'b1;
    end
    if (i_src_set.crypto) begin
      st_next.flags_two[cpu_irq_flags_pkg::BIT_CRYPTO_HI] = 1'b1;
      st_next.flags_two[cpu_irq_flags_pkg::BIT_CRYPTO_LO] = 1'b1;
    end

    // sticky event status, write one to clear, set wins
    if (wr_status) begin
      st_next.status = st_reg.status & ~i_hwdata[4:0];
    end
    st_next.status = st_next.status | i_src_set;

    // requests toward the cpu, gated by the enables
    st_next.req.serial1_rx = st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL1] &
                             st_next.enable.serial1_rx;
    st_next.req.converter  = st_next.flags_one[cpu_irq_flags_pkg::BIT_CONVERTER] &
                             st_next.enable.converter;
    st_next.req.serial0_rx = st_next.flags_one[cpu_irq_flags_pkg::BIT_SERIAL0] &
                             st_next.enable.serial0_rx;
    st_next.req.radio_xfer = st_next.flags_one[cpu_irq_flags_pkg::BIT_RADIO] &
                             st_next.enable.radio_xfer;
    st_next.req.crypto     = (st_next.flags_two[cpu_irq_flags_pkg::BIT_CRYPTO_HI] |
                              st_next.flags_two[cpu_irq_flags_pkg::BIT_CRYPTO_LO]) &
                             st_next.enable.crypto;
    st_next.irq            = |(st_next.status & st_next.mask);

    // address phase capture; only word writes are taken
    st_next.hreadyout = 1'b1;
    if (i_hready) begin
      st_next.dp_valid = i_hsel && i_htrans[1];
      st_next.dp_write = i_hwrite && (i_hsize == cpu_irq_flags_pkg::HSIZE_WORD);
      st_next.dp_addr  = i_haddr[7:0];
    end

    // read data from the updated state so a just-written value reads back
    if (addr_read) begin
      st_next.hrdata = read_mux(i_haddr[7:0], st_next);
    end else begin
      st_next.hrdata = 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_reg.flags_one <= cpu_irq_flags_pkg::FLAGS_ONE_RST;
      st_reg.flags_two <= cpu_irq_flags_pkg::FLAGS_TWO_RST;
      st_reg.enable    <= cpu_irq_flags_pkg::SRC_RST;
      st_reg.status    <= cpu_irq_flags_pkg::SRC_RST;
      st_reg.mask      <= cpu_irq_flags_pkg::SRC_RST;
      st_reg.dp_valid  <= 1'b0;
      st_reg.dp_write  <= 1'b0;
      st_reg.dp_addr   <= 8'h0;
      st_reg.hrdata    <= 32'h0;
      st_reg.hreadyout <= 1'b1;
      st_reg.irq       <= 1'b0;
      st_reg.req       <= cpu_irq_flags_pkg::SRC_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register, hresp tied to okay
  assign o_hrdata    = st_reg.hrdata;
  assign o_hreadyout = st_reg.hreadyout;
  assign o_hresp     = 1'b0;
  assign o_irq       = st_reg.irq;
  assign o_irq_req   = st_reg.req;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // serial1 event sets its flag, even with a clear alongside
  serial1_set_a: assert property (i_src_set.serial1_rx |=> st_reg.flags_one[7])
    else $error("serial1 flag not set after event");

  // converter vector clears the flag when no set competes, even with a write alongside
  conv_clear_a: assert property (i_vector_taken.converter && !i_src_set.converter
                                 |=> !st_reg.flags_one[5])
    else $error("converter flag not cleared by vector");

  // serial0 event sets flag and, when enabled, request a cycle later
  serial0_req_a: assert property (i_src_set.serial0_rx && st_next.enable.serial0_rx
                                  |=> st_reg.flags_one[3] && o_irq_req.serial0_rx)
    else $error("serial0 flag or request missing");

  // radio flag holds when neither event, vector nor write touch it
  radio_hold_a: assert property (!i_src_set.radio_xfer && !i_vector_taken.radio_xfer
                                 && !wr_one |=> $stable(st_reg.flags_one[1]))
    else $error("radio flag changed without cause");

  // reserved ones only change through a software write
  reserved_ones_a: assert property (!wr_one |=> $stable(st_reg.flags_one[2])
                                    && $stable(st_reg.flags_one[0]))
    else $error("reserved bits of flags one changed");

  // vector without set drops the serial1 flag to not pending
  serial1_clear_a: assert property (i_vector_taken.serial1_rx && !i_src_set.serial1_rx
                                    |=> !st_reg.flags_one[7])
    else $error("serial1 flag still pending after vector");

  // crypto request sets both crypto flags at once
  crypto_both_a: assert property (i_src_set.crypto |=> st_reg.flags_two[1:0] == 2'h3)
    else $error("crypto flags not both set");

  // one software-set crypto flag requests when enabled
  crypto_sw_a: assert property (wr_two && (i_hwdata[1:0] != 2'h0) && st_next.enable.crypto
                                |=> o_irq_req.crypto)
    else $error("software crypto flag raised no request");

  // disabled sources still set their flags, without a request
  flag_no_en_a: assert property (i_src_set.converter && !st_next.enable.converter
                                 |=> st_reg.flags_one[5] && !o_irq_req.converter)
    else $error("disabled converter flag wrong");

  // enabled pending flag keeps its request up
  req_follow_a: assert property (st_reg.flags_one[1] && st_reg.enable.radio_xfer
                                 && !i_vector_taken.radio_xfer && !wr_one
                                 && !wr_enable |=> o_irq_req.radio_xfer)
    else $error("radio request missing while pending");

  // set and vector together in one cycle leave the flag set
  set_wins_a: assert property (i_src_set.converter && i_vector_taken.converter
                               |=> st_reg.flags_one[5])
    else $error("converter event lost to vector clear");

  // unmasked pending status keeps the interrupt output high
  irq_out_a: assert property (st_reg.status.serial0_rx && st_reg.mask.serial0_rx
                              && !wr_status && !wr_mask |=> o_irq)
    else $error("interrupt output low with unmasked status");

  // converter event sets its flag whatever else happens
  converter_set_a: assert property (i_src_set.converter
                                    |=> st_reg.flags_one[5])
    else $error("converter flag not set after event");

  // radio event sets its flag whatever else happens
  radio_set_a: assert property (i_src_set.radio_xfer
                                |=> st_reg.flags_one[1])
    else $error("radio flag not set after event");

  // serial0 vector without a set drops the flag
  serial0_clear_a: assert property (i_vector_taken.serial0_rx && !i_src_set.serial0_rx
                                    |=> !st_reg.flags_one[3])
    else $error("serial0 flag still pending after vector");

  // radio vector without a set drops the flag
  radio_clear_a: assert property (i_vector_taken.radio_xfer && !i_src_set.radio_xfer
                                  |=> !st_reg.flags_one[1])
    else $error("radio flag still pending after vector");

  // unused bits of flags one keep what software wrote
  unused_store_a: assert property (wr_one
                                   |=> st_reg.flags_one[6] == $past(i_hwdata[6])
                                       && st_reg.flags_one[4] == $past(i_hwdata[4]))
    else $error("unused bits of flags one lost the written value");

  // crypto flags change only by their event or a write
  crypto_hold_a: assert property (!i_src_set.crypto && !wr_two
                                  |=> $stable(st_reg.flags_two))
    else $error("flags two changed without cause");

  // software clearing both crypto flags drops the request
  crypto_req_off_a: assert property (wr_two && i_hwdata[1:0] == 2'h0 && !i_src_set.crypto
                                     |=> !o_irq_req.crypto)
    else $error("crypto request stayed after both flags cleared");

  // disabled crypto source still sets both flags, no request
  crypto_no_en_a: assert property (i_src_set.crypto && !st_next.enable.crypto
                                   |=> st_reg.flags_two[1:0] == 2'h3 && !o_irq_req.crypto)
    else $error("disabled crypto flags wrong");

  // a disabled serial1 source never reaches the cpu
  serial1_no_en_a: assert property (!st_next.enable.serial1_rx
                                    |=> !o_irq_req.serial1_rx)
    else $error("serial1 request raised while disabled");

  // enabled serial1 event raises its request next cycle
  serial1_req_a: assert property (i_src_set.serial1_rx && st_next.enable.serial1_rx
                                  |=> o_irq_req.serial1_rx)
    else $error("serial1 request missing after event");

  // enabled converter event raises its request next cycle
  converter_req_a: assert property (i_src_set.converter && st_next.enable.converter
                                    |=> o_irq_req.converter)
    else $error("converter request missing after event");

  // enabled radio event raises its request next cycle
  radio_req_a: assert property (i_src_set.radio_xfer && st_next.enable.radio_xfer
                                |=> o_irq_req.radio_xfer)
    else $error("radio request missing after event");

  // status bits fall only through a write-one-to-clear
  status_sticky_a: assert property (!wr_status
                                    |=> ($past(st_reg.status) & ~st_reg.status) == 5'h0)
    else $error("status bit dropped without a clear");

endmodule : cpu_interrupt_flag_regs

`default_nettype wire

// File: core/cpu_irq_flags_pkg.sv
// constants, types and state layout of the cpu interrupt flag registers
package cpu_irq_flags_pkg;

  // ---------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS    = 8'h00;
  localparam logic [7:0] ADDR_MASK      = 8'h04;
  localparam logic [7:0] ADDR_ENABLE    = 8'h08;
  localparam logic [7:0] ADDR_FLAGS_ONE = 8'h88;
  localparam logic [7:0] ADDR_FLAGS_TWO = 8'h98;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int unsigned BIT_SERIAL1   = 7;
  localparam int unsigned BIT_CONVERTER = 5;
  localparam int unsigned BIT_SERIAL0   = 3;
  localparam int unsigned BIT_RADIO     = 1;
  localparam int unsigned BIT_CRYPTO_HI = 1;
  localparam int unsigned BIT_CRYPTO_LO = 0;
  localparam logic [7:0] FLAGS_ONE_RST  = 8'h05;
  localparam logic [7:0] FLAGS_TWO_RST  = 8'h00;
  localparam logic [4:0] SRC_RST        = 5'h00;
  localparam logic [2:0] HSIZE_WORD     = 3'h2;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // one bit per source; also the layout of status, mask and enable
  typedef struct packed {
    logic serial1_rx;   // bit 4, shared with audio receive
    logic converter;    // bit 3
    logic serial0_rx;   // bit 2
    logic radio_xfer;   // bit 1
    logic crypto;       // bit 0
  } src_t;

  // vector-taken strobes of the hardware-cleared flags
  typedef struct packed {
    logic serial1_rx;
    logic converter;
    logic serial0_rx;
    logic radio_xfer;
  } vec_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]  flags_one;
    logic [7:0]  flags_two;
    src_t        enable;
    src_t        status;
    src_t        mask;
    logic        dp_valid;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        irq;
    src_t        req;
  } state_t;

endpackage : cpu_irq_flags_pkg

// File: dv/cpu_irq_partner.sv
// cpu interrupt logic and peripheral event sources facing the flag registers
`timescale 1ns/10ps
`default_nettype none

module cpu_irq_partner (
  input  wire logic                    i_clk_sys,      // system clock
  input  wire cpu_irq_flags_pkg::src_t i_irq_req,      // enabled requests from the flags
  output var  cpu_irq_flags_pkg::src_t o_src_set,      // peripheral set events
  output var  cpu_irq_flags_pkg::vec_t o_vector_taken  // cpu vectored strobes
);
  logic                    auto_vec;
  cpu_irq_flags_pkg::vec_t vec_man;
  cpu_irq_flags_pkg::vec_t vec_auto;

  initial begin
    o_src_set = '0;
    vec_man   = '0;
    vec_auto  = '0;
    auto_vec  = 1'b0;
  end

  // cpu takes a pending enabled request other than crypto one cycle later, one strobe per request
  always @(posedge i_clk_sys) begin
    vec_auto <= (auto_vec && vec_auto == 4'h0) ? i_irq_req[4:1] : 4'h0;
  end

  assign o_vector_taken = vec_man | vec_auto;

  // one-cycle set and vector strobes, both may land in the same cycle
  task automatic fire(input cpu_irq_flags_pkg::src_t s, input cpu_irq_flags_pkg::vec_t v);
    @(posedge i_clk_sys);
    o_src_set <= s;
    vec_man   <= v;
    @(posedge i_clk_sys);
    o_src_set <= '0;
    vec_man   <= '0;
  endtask : fire
endmodule : cpu_irq_partner

`default_nettype wire

// File: dv/tb.sv
// self-checking testbench of the cpu interrupt flag registers
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic                    clk;
  logic                    rst;
  logic                    hsel;
  logic [31:0]             haddr;
  logic [1:0]              htrans;
  logic                    hwrite;
  logic [2:0]              hsize;
  logic [31:0]             hwdata;
  logic [31:0]             hrdata;
  logic                    hready;
  logic                    hresp;
  logic                    irq;
  logic [31:0]             rdata;
  cpu_irq_flags_pkg::src_t src_set;
  cpu_irq_flags_pkg::vec_t vec_taken;
  cpu_irq_flags_pkg::src_t irq_req;
  int                      num_errors;
  int                      n_tests;

  cpu_interrupt_flag_regs cpu_interrupt_flag_regs_i (
    .i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .i_src_set(src_set), .i_vector_taken(vec_taken), .o_hrdata(hrdata),
    .o_hreadyout(hready), .o_hresp(hresp), .o_irq(irq), .o_irq_req(irq_req));

  cpu_irq_partner cpu_irq_partner_i (
    .i_clk_sys(clk), .i_irq_req(irq_req), .o_src_set(src_set), .o_vector_taken(vec_taken));

  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    num_errors++;
    summarize();
  endtask : wait_rdy

  // single word transfer; read data lands in rdata
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= cpu_irq_flags_pkg::HSIZE_WORD;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rdata = hrdata;
  endtask : ahb

  // main sequence
  initial begin
    int i;
    num_errors = 0;
    n_tests    = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = cpu_irq_flags_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
    check(rdata, 32'h05);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'h0);
    check(rdata, 32'h00);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_STATUS, 32'h0);
    check(rdata, 32'h00);
    // each vectored source sets its flag with enables off, its vector clears it
    for (i = 0; i < 4; i++) begin
      cpu_irq_partner_i.fire(5'h10 >> i, 4'h0);
      ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
      check(rdata, 32'h05 | (32'h80 >> (2 * i)));
      check({27'h0, irq_req}, 32'h0);
      cpu_irq_partner_i.fire(5'h00, 4'h8 >> i);
      ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
      check(rdata, 32'h05);
    end
    // set and vector clear in the same cycle
    cpu_irq_partner_i.fire(5'h08, 4'h4);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
    check(rdata, 32'h25);
    cpu_irq_partner_i.fire(5'h00, 4'h4);
    // crypto request sets both flags
    cpu_irq_partner_i.fire(5'h01, 4'h0);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'h0);
    check(rdata, 32'h03);
    // software set of either crypto flag raises a request
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_ENABLE, 32'h01);
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'h00);
    @(negedge clk);
    check({27'h0, irq_req}, 32'h00);
    for (i = 0; i < 2; i++) begin
      ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'h01 << i);
      @(negedge clk);
      check({27'h0, irq_req}, 32'h01);
    end
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'hfc);
    @(negedge clk);
    check({27'h0, irq_req}, 32'h00);
    // unused bits are storage; reserved bits kept at one
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h55);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
    check(rdata, 32'h55);
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h05);
    // enabled request reaches the cpu, which vectors and clears the flag
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_ENABLE, 32'h1e);
    cpu_irq_partner_i.auto_vec = 1'b1;
    for (i = 0; i < 4; i++) begin
      cpu_irq_partner_i.fire(5'h10 >> i, 4'h0);
      @(negedge clk);
      check({27'h0, irq_req}, 32'h10 >> i);
      repeat (3) @(posedge clk);
      ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
      check(rdata, 32'h05);
    end
    // sticky status, mask and write-one-to-clear
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_STATUS, 32'h0);
    check(rdata, 32'h1f);
    check({31'h0, irq}, 32'h0);
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_MASK, 32'h04);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_STATUS, 32'h04);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_STATUS, 32'h0);
    check(rdata, 32'h1b);
    check({31'h0, irq}, 32'h0);
    // unmapped place reads zero and ignores writes
    ahb(1'b1, 8'h40, 32'hff);
    ahb(1'b0, 8'h40, 32'h0);
    check(rdata, 32'h0);
    check({31'h0, hresp}, 32'h0);
    // reset in mid-run brings flags one, flags two, status and irq back to their reset values
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h55);
    ahb(1'b1, cpu_irq_flags_pkg::ADDR_MASK, 32'h1f);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    rst <= 1'b0;
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_ONE, 32'h0);
    check(rdata, 32'h05);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_FLAGS_TWO, 32'h0);
    check(rdata, 32'h00);
    ahb(1'b0, cpu_irq_flags_pkg::ADDR_STATUS, 32'h0);
    check(rdata, 32'h00);
    summarize();
  end
endmodule : tb

`default_nettype wire
